// ---- common/bsowc_pkg.sv ----
// package: register map, codes and reset values of the switch and open wire checker
package bsowc_pkg;
  localparam int unsigned CHANNELS       = 16;
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_SELECT     = 12'h004;
  localparam logic [11:0] OFS_THRESHOLD  = 12'h008;
  localparam logic [11:0] OFS_BAR_MAP    = 12'h00c;
  localparam logic [11:0] OFS_SW_MAP     = 12'h010;
  localparam logic [11:0] OFS_STATUS     = 12'h014;
  localparam logic [11:0] OFS_SW_LOW     = 12'h018;
  localparam logic [11:0] OFS_SW_HIGH    = 12'h01c;
  localparam logic [11:0] OFS_SENSE_OW   = 12'h020;
  localparam logic [11:0] OFS_BAL_OW     = 12'h024;
  localparam logic [11:0] OFS_AUX_CELL   = 12'h028;
  localparam logic [11:0] OFS_DIAG_AUX   = 12'h02c;
  localparam logic [11:0] OFS_FILTER     = 12'h030;
  localparam logic [11:0] OFS_BAR_RES    = 12'h034;
  localparam logic [5:0]  CELL_PAGE      = 6'h01;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned GO_BIT         = 3;
  localparam int unsigned SINK_LSB       = 4;
  localparam int unsigned NUM_LSB        = 8;
  localparam int unsigned ST_ABORT       = 0;
  localparam int unsigned ST_AUX_RDY     = 1;
  localparam int unsigned ST_SW_RDY      = 2;
  localparam int unsigned ST_SENSE_RDY   = 3;
  localparam int unsigned ST_BAL_RDY     = 4;
  localparam int unsigned ST_BUSY        = 5;
  localparam logic [2:0]  CMP_SENSE_OW   = 3'h2;
  localparam logic [2:0]  CMP_BAL_OW     = 3'h3;
  localparam logic [2:0]  CMP_SWITCH     = 3'h4;
  localparam logic [4:0]  AUX_ALL        = 5'h00;
  localparam logic [4:0]  AUX_LOCK_MAX   = 5'h10;
  localparam logic [4:0]  NUM_CELLS_RST  = 5'h10;
  localparam logic [15:0] AUX_RES_RST    = 16'h8000;
  localparam logic [15:0] FAULT_ABORT    = 16'hffff;
  localparam int unsigned SW_MAX_ON      = 8;
  localparam int unsigned BAR_MAX        = 2;
  typedef enum logic {BSOWC_IDLE, BSOWC_RUN} bsowc_state_type;
endpackage : bsowc_pkg

// ---- design/bsowc_top.sv ----
// design: balancing switch and open wire comparison sequencer with apb registers
//
// Functional notes
// - invalid switch check start sets abort and both ready flags, switch faults 0xFFFF.
// - aborted run with locked aux channel resets aux cell result to 0x8000.
// - aux selector giving no measurement blocks start, aux result keeps its value.
// - locked channel above configured cell count blocks the start.
// - bad bar map (adjacent, bottom, over two, hits lock) blocks the start.
// - either converter off or not continuous blocks the start.
// - balancing running and not paused blocks the switch check.
// - over eight switches or three consecutive switches blocks the start.
// - pin sinks and bottom sources are driven from the sink control field.
// - sense check uses main readings, balance check uses aux readings.
// - locked balance check reports the aux reading used; sense readings not.
// - sense check compares every active channel, locked balance check only the locked one, against the threshold.
// - finished open wire check sets its matching ready flag.
// - results held in sense and balance fault registers for host reads.
// - up to one dedicated bar and two bars on non-bottom sense channels.
// - dedicated bar result has its own filter setting and result register.
// - bar on sense channel reads as that cell with the cell filter.
// - enabled switch fails unless aux below half main; ready flag at finish.
`timescale 1ns/1ps
module bsowc_top
  import bsowc_pkg::*;
#(
  parameter int unsigned N = CHANNELS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_valid,
  input  wire logic [3:0]  main_chan,
  input  wire logic [15:0] main_data,
  input  wire logic        aux_valid,
  input  wire logic [3:0]  aux_chan,
  input  wire logic [15:0] aux_data,
  input  wire logic        bar_valid,
  input  wire logic [15:0] bar_data,
  input  wire logic        main_continuous,
  input  wire logic        aux_continuous,
  input  wire logic        balancing_running,
  input  wire logic        balancing_paused,
  output logic      [1:0]  pin_sink_control
);

  function automatic logic [4:0] ones(input logic [N-1:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < N; i++) begin
      c = c + {4'h0, v[i]};
    end
    return c;
  endfunction : ones

  // first order low pass, shift 0 passes the sample through
  function automatic logic [15:0] lowpass(input logic [15:0] y, input logic [15:0] x, input logic [1:0] k);
    logic signed [16:0] diff;
    diff = $signed({x[15], x}) - $signed({y[15], y});
    diff = diff >>> k;
    return y + diff[15:0];
  endfunction : lowpass

  bsowc_state_type state_q, state_d;
  logic [2:0]  mode_q, mode_d;
  logic [N-1:0] need_q, need_d, seen_q, seen_d;
  logic [2:0]  sel_q, sel_d;
  logic [1:0]  sink_q, sink_d;
  logic [4:0]  aux_sel_q, aux_sel_d, num_q, num_d;
  logic [15:0] thr_q, thr_d, bar_map_q, bar_map_d, sw_map_q, sw_map_d;
  logic [5:0]  stat_q, stat_d;
  logic [15:0] sw_fault_q, sw_fault_d, sense_f_q, sense_f_d, bal_f_q, bal_f_d;
  logic [15:0] aux_res_q, aux_res_d, diag_aux_q, diag_aux_d, bar_res_q, bar_res_d;
  logic [1:0]  cell_k_q, cell_k_d, bar_k_q, bar_k_d;
  logic [15:0] main_raw_q [N];
  logic [15:0] main_raw_d [N];
  logic [15:0] cell_res_q [N];
  logic [15:0] cell_res_d [N];
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;

  logic        wr_en, rd_phase, go_req, start_sw, start_ow, start_bad, locked;
  logic        bad_aux, bad_num, bad_bar, bad_conv, bad_bal, bad_sw, done;
  logic [N-1:0] lock_mask, active_mask, aux_need;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign wr_en    = psel && penable && pready_q && pwrite && !pslverr_q;
  assign rd_phase = psel && penable && !pready_q;
  assign go_req   = wr_en && paddr == OFS_CTRL && pwdata[GO_BIT] && state_q == BSOWC_IDLE;
  assign locked   = aux_sel_q != AUX_ALL && aux_sel_q <= AUX_LOCK_MAX;
  assign lock_mask   = locked ? (N'(1) << (aux_sel_q - 5'h01)) : '0;
  assign active_mask = (N'(1) << num_q) - N'(1);
  assign aux_need    = locked ? lock_mask & active_mask : active_mask;
  assign bad_aux  = aux_sel_q > AUX_LOCK_MAX;
  assign bad_num  = locked && aux_sel_q > num_q;
  assign bad_bar  = (bar_map_q & (bar_map_q >> 1)) != '0 || bar_map_q[0]
                    || ones(bar_map_q) > 5'(BAR_MAX) || (bar_map_q & lock_mask) != '0;
  assign bad_conv = !main_continuous || !aux_continuous;
  assign bad_bal  = balancing_running && !balancing_paused;
  assign bad_sw   = ones(sw_map_q) > 5'(SW_MAX_ON) || (sw_map_q & (sw_map_q >> 1) & (sw_map_q >> 2)) != '0;
  assign start_sw  = go_req && pwdata[SEL_LSB +: 3] == CMP_SWITCH;
  assign start_bad = start_sw && (bad_aux || bad_num || bad_bar || bad_conv || bad_bal || bad_sw);
  assign start_ow  = go_req && (pwdata[SEL_LSB +: 3] == CMP_SENSE_OW || pwdata[SEL_LSB +: 3] == CMP_BAL_OW);
  assign done      = state_q == BSOWC_RUN && (seen_q | ~need_q) == '1;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr[11:6] == CELL_PAGE) begin
      rd_word = {16'h0000, cell_res_q[paddr[5:2]]};
    end else begin
      unique case (paddr)
        OFS_CTRL:      rd_word = {26'h0, sink_q, 1'b0, sel_q};
        OFS_SELECT:    rd_word = {19'h0, num_q, 3'h0, aux_sel_q};
        OFS_THRESHOLD: rd_word = {16'h0, thr_q};
        OFS_BAR_MAP:   rd_word = {16'h0, bar_map_q};
        OFS_SW_MAP:    rd_word = {16'h0, sw_map_q};
        OFS_STATUS:    rd_word = {26'h0, stat_q};
        OFS_SW_LOW:    rd_word = {24'h0, sw_fault_q[7:0]};
        OFS_SW_HIGH:   rd_word = {24'h0, sw_fault_q[15:8]};
        OFS_SENSE_OW:  rd_word = {16'h0, sense_f_q};
        OFS_BAL_OW:    rd_word = {16'h0, bal_f_q};
        OFS_AUX_CELL:  rd_word = {16'h0, aux_res_q};
        OFS_DIAG_AUX:  rd_word = {16'h0, diag_aux_q};
        OFS_FILTER:    rd_word = {28'h0, bar_k_q, cell_k_q};
        OFS_BAR_RES:   rd_word = {16'h0, bar_res_q};
        default:       rd_hit  = 1'b0;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;       mode_d = mode_q;       need_d = need_q;     seen_d = seen_q;
    sel_d = sel_q;           sink_d = sink_q;       aux_sel_d = aux_sel_q; num_d = num_q;
    thr_d = thr_q;           bar_map_d = bar_map_q; sw_map_d = sw_map_q; stat_d = stat_q;
    sw_fault_d = sw_fault_q; sense_f_d = sense_f_q; bal_f_d = bal_f_q;
    aux_res_d = aux_res_q;   diag_aux_d = diag_aux_q; bar_res_d = bar_res_q;
    cell_k_d = cell_k_q;     bar_k_d = bar_k_q;
    main_raw_d = main_raw_q;
    cell_res_d = cell_res_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (rd_phase) begin
      pready_d  = 1'b1;
      pslverr_d = !rd_hit;
      prdata_d  = rd_hit ? rd_word : 32'h0000_0000;
    end
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          sel_d  = pwdata[SEL_LSB +: 3];
          sink_d = pwdata[SINK_LSB +: 2];
        end
        OFS_SELECT:    begin aux_sel_d = pwdata[4:0]; num_d = pwdata[NUM_LSB +: 5]; end
        OFS_THRESHOLD: thr_d = pwdata[15:0];
        OFS_BAR_MAP:   bar_map_d = pwdata[15:0];
        OFS_SW_MAP:    sw_map_d = pwdata[15:0];
        OFS_STATUS:    stat_d[ST_BAL_RDY:ST_ABORT] = stat_q[ST_BAL_RDY:ST_ABORT] & ~pwdata[ST_BAL_RDY:ST_ABORT];
        OFS_FILTER:    begin cell_k_d = pwdata[1:0]; bar_k_d = pwdata[3:2]; end
        default:       ;
      endcase
    end
    if (main_valid) begin
      main_raw_d[main_chan] = main_data;
      cell_res_d[main_chan] = lowpass(cell_res_q[main_chan], main_data, cell_k_q);
    end
    if (bar_valid) begin
      bar_res_d = lowpass(bar_res_q, bar_data, bar_k_q);
    end
    if (aux_valid && locked && lock_mask[aux_chan]) begin
      aux_res_d = aux_data;
    end
    if (start_bad) begin
      stat_d[ST_ABORT]   = 1'b1;
      stat_d[ST_AUX_RDY] = 1'b1;
      stat_d[ST_SW_RDY]  = 1'b1;
      sw_fault_d = FAULT_ABORT;
      if (locked) begin
        aux_res_d = AUX_RES_RST;
      end
    end else if (start_sw || start_ow) begin
      state_d = BSOWC_RUN;
      mode_d  = pwdata[SEL_LSB +: 3];
      seen_d  = '0;
      unique case (pwdata[SEL_LSB +: 3])
        CMP_SENSE_OW: begin need_d = active_mask; sense_f_d = '0; end
        CMP_BAL_OW:   begin need_d = aux_need;    bal_f_d = '0; end
        default:      begin need_d = aux_need & sw_map_q; sw_fault_d = '0; end
      endcase
    end
    if (state_q == BSOWC_RUN) begin
      if (mode_q == CMP_SENSE_OW && main_valid && need_q[main_chan]) begin
        seen_d[main_chan] = 1'b1;
        sense_f_d[main_chan] = $signed(main_data) < $signed(thr_q);
      end
      if (mode_q != CMP_SENSE_OW && aux_valid && need_q[aux_chan]) begin
        seen_d[aux_chan] = 1'b1;
        if (locked) begin
          diag_aux_d = aux_data;
        end
        if (mode_q == CMP_BAL_OW) begin
          bal_f_d[aux_chan] = $signed(aux_data) < $signed(thr_q);
        end else begin
          sw_fault_d[aux_chan] = !($signed(aux_data) < ($signed(main_raw_q[aux_chan]) >>> 1));
        end
      end
      if (done) begin
        state_d = BSOWC_IDLE;
        unique case (mode_q)
          CMP_SENSE_OW: stat_d[ST_SENSE_RDY] = 1'b1;
          CMP_BAL_OW:   stat_d[ST_BAL_RDY] = 1'b1;
          default:      stat_d[ST_SW_RDY] = 1'b1;
        endcase
      end
    end
    stat_d[ST_BUSY] = state_d == BSOWC_RUN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BSOWC_IDLE;  mode_q <= 3'h0;     need_q <= '0;       seen_q <= '0;
      sel_q <= 3'h0;          sink_q <= 2'h0;     aux_sel_q <= AUX_ALL; num_q <= NUM_CELLS_RST;
      thr_q <= 16'h0000;      bar_map_q <= 16'h0000; sw_map_q <= 16'h0000; stat_q <= 6'h00;
      sw_fault_q <= 16'h0000; sense_f_q <= 16'h0000; bal_f_q <= 16'h0000;
      aux_res_q <= AUX_RES_RST; diag_aux_q <= AUX_RES_RST; bar_res_q <= 16'h0000;
      cell_k_q <= 2'h0;       bar_k_q <= 2'h0;
      for (int i = 0; i < N; i++) begin
        main_raw_q[i] <= 16'h0000;
        cell_res_q[i] <= 16'h0000;
      end
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;     mode_q <= mode_d;   need_q <= need_d;   seen_q <= seen_d;
      sel_q <= sel_d;         sink_q <= sink_d;   aux_sel_q <= aux_sel_d; num_q <= num_d;
      thr_q <= thr_d;         bar_map_q <= bar_map_d; sw_map_q <= sw_map_d; stat_q <= stat_d;
      sw_fault_q <= sw_fault_d; sense_f_q <= sense_f_d; bal_f_q <= bal_f_d;
      aux_res_q <= aux_res_d; diag_aux_q <= diag_aux_d; bar_res_q <= bar_res_d;
      cell_k_q <= cell_k_d;   bar_k_q <= bar_k_d;
      main_raw_q <= main_raw_d;
      cell_res_q <= cell_res_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign pin_sink_control = sink_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sw_go_s;
    start_sw;
  endsequence
  sequence bad_go_s;
    start_bad;
  endsequence

  abort_flags_a: assert property (bad_go_s |=> stat_q[ST_ABORT] && stat_q[ST_AUX_RDY]
    && stat_q[ST_SW_RDY] && sw_fault_q == 16'hffff && state_q == BSOWC_IDLE)
    else $error("abort did not set flags and faults");
  aux_reset_a: assert property (bad_go_s ##0 locked |=> aux_res_q == 16'h8000)
    else $error("locked aux result not reset on abort");
  aux_keep_a: assert property (sw_go_s ##0 bad_aux && !aux_valid |=> $stable(aux_res_q) && !stat_q[ST_BUSY])
    else $error("invalid aux selector changed result or started");
  cells_over_a: assert property (sw_go_s ##0 bad_num |=> state_q == BSOWC_IDLE)
    else $error("start above cell count");
  bar_map_a: assert property (sw_go_s ##0 bad_bar |=> state_q == BSOWC_IDLE ##1 state_q == BSOWC_IDLE)
    else $error("start with bad bar map");
  conv_off_a: assert property (sw_go_s ##0 bad_conv |=> stat_q[ST_ABORT])
    else $error("converter off did not abort");
  bal_run_a: assert property (sw_go_s ##0 bad_bal |=> !stat_q[ST_BUSY])
    else $error("start while balancing");
  switch_lim_a: assert property (sw_go_s ##0 bad_sw |=> sw_fault_q == 16'hffff)
    else $error("switch limit not enforced");
  ow_ready_a: assert property (done && mode_q == CMP_SENSE_OW |=> stat_q[ST_SENSE_RDY] && state_q == BSOWC_IDLE)
    else $error("sense ready not set at completion");
  switch_fail_a: assert property (state_q == BSOWC_RUN && mode_q == CMP_SWITCH && aux_valid && need_q[aux_chan]
    && !($signed(aux_data) < ($signed(main_raw_q[aux_chan]) >>> 1)) |=> sw_fault_q[$past(aux_chan)])
    else $error("failing switch not flagged");

endmodule : bsowc_top

// ---- test/bsowc_adc_model.sv ----
// partner model: converter sample streams as seen by the comparison sequencer
`timescale 1ns/1ps
module bsowc_adc_model
  import bsowc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              en,
  input  wire logic [4:0]        aux_lock,
  input  wire logic [15:0][15:0] main_val,
  input  wire logic [15:0][15:0] aux_val,
  input  wire logic [15:0]       bar_val,
  output logic                   main_valid,
  output logic [3:0]             main_chan,
  output logic [15:0]            main_data,
  output logic                   aux_valid,
  output logic [3:0]             aux_chan,
  output logic [15:0]            aux_data,
  output logic                   bar_valid,
  output logic [15:0]            bar_data
);
  logic [3:0] idx_q;
  logic [3:0] ach;
  assign ach = (aux_lock != AUX_ALL && aux_lock <= AUX_LOCK_MAX) ? 4'(aux_lock - 5'h01) : idx_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 4'h0;
      {main_valid, aux_valid, bar_valid} <= 3'b000;
      {main_chan, aux_chan} <= 8'h00;
      {main_data, aux_data, bar_data} <= 48'h0;
    end else begin
      idx_q <= idx_q + 4'h1;
      main_valid <= en;
      aux_valid <= en;
      bar_valid <= en && idx_q == 4'h0;
      if (en) begin
        main_chan <= idx_q;
        main_data <= main_val[idx_q];
        aux_chan <= ach;
        aux_data <= aux_val[ach];
        bar_data <= bar_val;
      end else begin
        // stale lines toggle so nothing is read as a lucky match
        main_data <= ~main_data;
        aux_data <= ~aux_data;
        bar_data <= ~bar_data;
      end
    end
  end
endmodule : bsowc_adc_model

// ---- test/balancing_switch_open_wire_check_tb.sv ----
// testbench: bus driver, sample streams and reference model for the comparison sequencer
`timescale 1ns/1ps
module balancing_switch_open_wire_check_tb;
  import bsowc_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata, rq;
  logic              pready, pslverr, re;
  logic              main_valid, aux_valid, bar_valid;
  logic [3:0]        main_chan, aux_chan;
  logic [15:0]       main_data, aux_data, bar_data, thr, exp16, bar_v;
  logic [3:0]        lv = 4'b1100;
  logic [1:0]        pin_sink_control;
  logic              en = 1'b0;
  logic [4:0]        lock = 5'h00;
  logic [15:0][15:0] mv, av;
  logic [31:0]       seed = 32'he270;
  int                failures = 0;
  int                cmp_count = 0;
  logic [15:0]       cell_m [16] = '{default: 16'h0};
  logic [15:0]       bar_m = 16'h0;
  logic [15:0]       swm;
  int                kc = 0;
  int                kb = 0;
  // each row breaks exactly one start condition of the switch check
  logic [31:0] ab_sel [11] = '{32'h080a, 32'h1011, 32'h1000, 32'h1000, 32'h1000, 32'h1005,
                               32'h1000, 32'h1000, 32'h1000, 32'h1000, 32'h1000};
  logic [15:0] ab_bar [11] = '{16'h0, 16'h0, 16'h0006, 16'h0001, 16'h0124, 16'h0010,
                               16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] ab_sw [11] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h0007, 16'hd555};
  logic [3:0]  ab_lv [11] = '{4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'h4, 4'h8, 4'he, 4'hc, 4'hc};

  always #12.5 pclk = ~pclk;

  bsowc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_valid(main_valid), .main_chan(main_chan), .main_data(main_data), .aux_valid(aux_valid),
    .aux_chan(aux_chan), .aux_data(aux_data), .bar_valid(bar_valid), .bar_data(bar_data),
    .main_continuous(lv[3]), .aux_continuous(lv[2]), .balancing_running(lv[1]),
    .balancing_paused(lv[0]), .pin_sink_control(pin_sink_control));

  bsowc_adc_model adc (.pclk(pclk), .presetn(presetn), .en(en), .aux_lock(lock), .main_val(mv),
    .aux_val(av), .bar_val(bar_v), .main_valid(main_valid), .main_chan(main_chan),
    .main_data(main_data), .aux_valid(aux_valid), .aux_chan(aux_chan), .aux_data(aux_data),
    .bar_valid(bar_valid), .bar_data(bar_data));

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  // reference low pass: y moves by (x - y) shifted right arithmetically by k
  function automatic logic [15:0] filt(input logic [15:0] y, input logic [15:0] x, input int k);
    int d;
    d = int'($signed(x)) - int'($signed(y));
    d = d >>> k;
    return 16'(int'(y) + d);
  endfunction : filt

  // reference filtered cell and bar results, fed by the same sample streams
  always @(posedge pclk) begin
    if (main_valid === 1'b1) begin
      cell_m[main_chan] = filt(cell_m[main_chan], main_data, kc);
    end
    if (bar_valid === 1'b1) begin
      bar_m = filt(bar_m, bar_data, kb);
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask : chk

  // one apb transfer; result left in rq and re
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      failures++;
      test_done();
    end
  endtask : apb

  task automatic wait_bit(input int b);
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rq[b] === 1'b1) break;
    end
    if (n == 100) begin
      failures++;
      test_done();
    end
  endtask : wait_bit

  initial begin
    int i;
    int m;
    int r;
    for (i = 0; i < 16; i++) begin
      seed = nx(seed);
      mv[i] = seed[15:0];
      seed = nx(seed);
      av[i] = seed[15:0];
    end
    thr = {{6{seed[9]}}, seed[9:0]};
    bar_v = seed[31:16];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped_err", {31'h0, re}, 32'h1);
    chk("unmapped_data", rq, 32'h0);
    apb(1'b0, OFS_SELECT, 32'h0);
    chk("select_reset", rq, {19'h0, NUM_CELLS_RST, 3'h0, AUX_ALL});
    apb(1'b0, OFS_AUX_CELL, 32'h0);
    chk("aux_cell_reset", rq, {16'h0, AUX_RES_RST});
    apb(1'b1, OFS_THRESHOLD, {16'h0, thr});
    apb(1'b1, OFS_SELECT, 32'h0c00);
    apb(1'b1, OFS_CTRL, 32'h30);
    @(posedge pclk);
    chk("sink_on", {30'h0, pin_sink_control}, 32'h3);
    en <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h3a);
    wait_bit(ST_SENSE_RDY);
    chk("sense_ready", {26'h0, rq[5:0]}, 32'h08);
    exp16 = 16'h0;
    for (i = 0; i < 12; i++) exp16[i] = $signed(mv[i]) < $signed(thr);
    apb(1'b0, OFS_SENSE_OW, 32'h0);
    chk("sense_faults", rq, {16'h0, exp16});
    apb(1'b1, OFS_STATUS, 32'h1f);
    lock <= 5'h06;
    apb(1'b1, OFS_SELECT, 32'h1006);
    repeat (20) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h3b);
    wait_bit(ST_BAL_RDY);
    chk("balance_ready", {26'h0, rq[5:0]}, 32'h10);
    exp16 = 16'h0;
    exp16[5] = $signed(av[5]) < $signed(thr);
    apb(1'b0, OFS_BAL_OW, 32'h0);
    chk("balance_faults", rq, {16'h0, exp16});
    apb(1'b0, OFS_DIAG_AUX, 32'h0);
    chk("diag_aux", rq, {16'h0, av[5]});
    apb(1'b1, OFS_CTRL, 32'h0);
    @(posedge pclk);
    chk("sink_off", {30'h0, pin_sink_control}, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h1f);
    lock <= 5'h00;
    lv <= 4'b1111;
    apb(1'b1, OFS_SELECT, 32'h1000);
    // odd pairs first, then the remaining switches
    for (r = 0; r < 2; r++) begin
      swm = (r == 0) ? 16'h3333 : 16'hcccc;
      apb(1'b1, OFS_STATUS, 32'h1f);
      apb(1'b1, OFS_SW_MAP, {16'h0, swm});
      repeat (20) @(posedge pclk);
      apb(1'b1, OFS_CTRL, 32'h0c);
      wait_bit(ST_SW_RDY);
      chk("switch_ready", {26'h0, rq[5:0]}, 32'h04);
      exp16 = 16'h0;
      for (i = 0; i < 16; i++) begin
        m = $signed(mv[i]);
        exp16[i] = swm[i] && !($signed(av[i]) < (m >>> 1));
      end
      apb(1'b0, OFS_SW_LOW, 32'h0);
      chk("switch_low", rq, {24'h0, exp16[7:0]});
      apb(1'b0, OFS_SW_HIGH, 32'h0);
      chk("switch_high", rq, {24'h0, exp16[15:8]});
    end
    apb(1'b0, 12'h04c, 32'h0);
    chk("cell_result", rq, {16'h0, mv[3]});
    apb(1'b0, OFS_BAR_RES, 32'h0);
    chk("bar_result", rq, {16'h0, bar_v});
    en <= 1'b0;
    apb(1'b1, OFS_FILTER, 32'h9);
    kc = 1;
    kb = 2;
    mv[3] = ~mv[3];
    bar_v = ~bar_v;
    en <= 1'b1;
    repeat (40) @(posedge pclk);
    en <= 1'b0;
    apb(1'b0, OFS_FILTER, 32'h0);
    chk("filter_cfg", rq, 32'h9);
    apb(1'b0, 12'h04c, 32'h0);
    chk("cell_filtered", rq, {16'h0, cell_m[3]});
    apb(1'b0, OFS_BAR_RES, 32'h0);
    chk("bar_filtered", rq, {16'h0, bar_m});
    for (i = 0; i < 11; i++) begin
      apb(1'b1, OFS_STATUS, 32'h1f);
      apb(1'b1, OFS_SELECT, ab_sel[i]);
      apb(1'b1, OFS_BAR_MAP, {16'h0, ab_bar[i]});
      apb(1'b1, OFS_SW_MAP, {16'h0, ab_sw[i]});
      lv <= ab_lv[i];
      apb(1'b1, OFS_CTRL, 32'h0c);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("abort_status", rq, 32'h7);
      apb(1'b0, OFS_SW_HIGH, 32'h0);
      chk("abort_faults", rq, 32'hff);
      apb(1'b0, OFS_AUX_CELL, 32'h0);
      chk("aux_default", rq, {16'h0, AUX_RES_RST});
    end
    test_done();
  end
endmodule : balancing_switch_open_wire_check_tb
